/* File: rtl/frsft_pkg.sv */
// constants and carrier types for one fifo lane with sampled port clocks
// assumes the system clock runs far faster than either port clock
package frsft_pkg;

    localparam int UNIT_W = 10;
    localparam int WIDE_W = 20;
    localparam int OFS_W = 16;
    localparam int AGE_W = 4;
    localparam int CLK_MHZ = 10;

    // least write-to-read separation for a flag to see a port event
    localparam int SKEW_WINDOW_RISING_NS = 300;
    localparam int SKEW_WINDOW_FALLING_NS = 300;
    localparam int SKEW_RISE_INT = (SKEW_WINDOW_RISING_NS * CLK_MHZ + 999) / 1000;
    localparam int SKEW_FALL_INT = (SKEW_WINDOW_FALLING_NS * CLK_MHZ + 999) / 1000;
    localparam logic [AGE_W-1:0] SKEW_RISE_CYC =
        AGE_W'((SKEW_RISE_INT < 1) ? 1 : SKEW_RISE_INT);
    localparam logic [AGE_W-1:0] SKEW_FALL_CYC =
        AGE_W'((SKEW_FALL_INT < 1) ? 1 : SKEW_FALL_INT);
    localparam logic [AGE_W-1:0] AGE_MAX = {AGE_W{1'b1}};

    // mode encodings
    localparam logic FIFO_COUNT_QUAD = 1'b1;
    localparam int DUAL_LANE_A = 0;
    localparam int DUAL_LANE_B = 2;

    // flag reset values, all active low
    localparam logic EMPTY_RST = 1'b0;
    localparam logic READY_OUT_RST = 1'b1;
    localparam logic FULL_RST = 1'b1;
    localparam logic READY_IN_RST = 1'b1;
    localparam logic AEMPTY_RST = 1'b0;
    localparam logic AFULL_RST = 1'b1;
    localparam logic ECHO_RST = 1'b1;
    localparam logic DRIVE_OFF = 1'b1;

    typedef struct packed {
        logic write_clock;
        logic read_clock;
        logic write_select_n;
        logic write_enable_n;
        logic read_select_n;
        logic read_enable_n;
        logic output_enable_n;
        logic [WIDE_W-1:0] write_data;
        logic fifo_count_select;
        logic write_double_rate;
        logic read_double_rate;
        logic fall_through_select;
        logic flag_timing_select;
        logic input_width_select;
        logic output_width_select;
        logic [OFS_W-1:0] almost_empty_offset;
        logic [OFS_W-1:0] almost_full_offset;
    } frsft_pin_s;

endpackage : frsft_pkg

/* File: rtl/frsft_lane.sv */
// one fifo lane: write port, read port, flags, echo and output drive
// both port clocks are plain pins sampled by clk_sys_i; each port clock
// period must span several system cycles for edges to be seen
// Function
// - standard mode empty clears one read cycle later
// - write inside skew window adds one read cycle
// - fall-through output ready two read cycles later
// - double-rate write measures skew from falling edge
// - sync almost-empty clears one read cycle after writes
// - input ready returns one write cycle after read
// - sync almost-full clears one write cycle after read
// - echo low on delivered word, high otherwise
// - echo timed by the read clock
// - data driven only with select and enable low
// - dual mode uses lanes 0 and 2 only
// - quad fall-through mode set by configuration pins
// - 20-bit double-rate writes read as 10-bit words
// - 10-bit writes read as 20-bit double-rate words
// - flag timing select picks sync or split flags
module frsft_lane
    import frsft_pkg::*;
#(
    parameter int DEPTH = 64,
    parameter int LANE_ID = 0
) (
    input wire logic clk_sys_i, // system clock
    input wire logic rstn_i, // synchronous reset, active low
    input wire logic write_clock_i, // write port clock pin
    input wire logic read_clock_i, // read port clock pin
    input wire logic write_select_n_i, // write chip select
    input wire logic write_enable_n_i, // write enable
    input wire logic read_select_n_i, // read chip select
    input wire logic read_enable_n_i, // read enable
    input wire logic output_enable_n_i, // output enable
    input wire logic [WIDE_W-1:0] write_data_i, // write data
    input wire logic fifo_count_select_i, // 1 quad, 0 dual
    input wire logic write_double_rate_i, // write on both edges
    input wire logic read_double_rate_i, // read on both edges
    input wire logic fall_through_select_i, // 1 fall-through mode
    input wire logic flag_timing_select_i, // 1 synchronous almost flags
    input wire logic input_width_select_i, // 1 wide writes
    input wire logic output_width_select_i, // 1 wide reads
    input wire logic [OFS_W-1:0] almost_empty_offset_i, // almost-empty level
    input wire logic [OFS_W-1:0] almost_full_offset_i, // almost-full level
    output logic empty_flag_n_o, // standard mode empty
    output logic output_ready_n_o, // fall-through word ready
    output logic full_flag_n_o, // standard mode full
    output logic input_ready_n_o, // fall-through room ready
    output logic almost_empty_flag_n_o, // almost empty
    output logic almost_full_flag_n_o, // almost full
    output logic echo_read_enable_n_o, // new word placed on output
    output logic [WIDE_W-1:0] read_data_out_o, // output register
    output logic read_data_oe_n_o, // data pin enable, low drives
    output logic lane_used_o // lane active in this mode
);

    localparam int AW = $clog2(DEPTH);
    localparam int PW = AW + 1;
    localparam logic [OFS_W-1:0] DEPTH_W = OFS_W'(DEPTH);
    localparam logic [PW-1:0] ONE_P = PW'(1);
    localparam logic [PW-1:0] TWO_P = PW'(2);
    localparam logic [1:0] BUF_FULL = 2'h2;

    // pin synchroniser: first stage feeds only the second
    frsft_pin_s pin_meta;
    frsft_pin_s pin;
    always_ff @(posedge clk_sys_i) begin
        pin_meta <= '{write_clock_i, read_clock_i, write_select_n_i,
                      write_enable_n_i, read_select_n_i, read_enable_n_i,
                      output_enable_n_i, write_data_i, fifo_count_select_i,
                      write_double_rate_i, read_double_rate_i,
                      fall_through_select_i, flag_timing_select_i,
                      input_width_select_i, output_width_select_i,
                      almost_empty_offset_i, almost_full_offset_i};
        pin <= pin_meta;
    end

    // port clock edges
    logic wclk_d;
    logic rclk_d;
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            wclk_d <= 1'b0;
            rclk_d <= 1'b0;
        end else begin
            wclk_d <= pin.write_clock;
            rclk_d <= pin.read_clock;
        end
    end

    logic w_rise, w_fall, r_rise, r_fall, w_evt, r_evt, w_ref, r_ref;
    logic fwft, sync_flags;
    logic [PW-1:0] in_units, out_units;
    logic [AGE_W-1:0] w_skew;
    assign w_rise = pin.write_clock & ~wclk_d;
    assign w_fall = ~pin.write_clock & wclk_d;
    assign r_rise = pin.read_clock & ~rclk_d;
    assign r_fall = ~pin.read_clock & rclk_d;
    assign w_evt = w_rise | (pin.write_double_rate & w_fall);
    assign r_evt = r_rise | (pin.read_double_rate & r_fall);
    assign w_ref = pin.write_double_rate ? w_fall : w_rise;
    assign r_ref = pin.read_double_rate ? r_fall : r_rise;
    assign w_skew = pin.write_double_rate ? SKEW_FALL_CYC : SKEW_RISE_CYC;
    assign fwft = pin.fall_through_select;
    assign sync_flags = pin.flag_timing_select;
    assign in_units = pin.input_width_select ? TWO_P : ONE_P;
    assign out_units = pin.output_width_select ? TWO_P : ONE_P;

    // storage in 10-bit units; wide words occupy two units, low half first
    logic [UNIT_W-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr, wr_ptr_prev, rd_ptr, rd_ptr_prev, rd_cptr;
    logic [PW-1:0] r_wsnap1, r_wsnap2, w_rsnap;
    logic [AGE_W-1:0] w_age, r_age;

    // write side: free space judged from the write-side view of the reader
    logic [PW-1:0] used_w;
    logic [OFS_W-1:0] free_w;
    logic wr_ok;
    assign used_w = wr_ptr - w_rsnap;
    assign free_w = DEPTH_W - OFS_W'(used_w);
    assign wr_ok = w_evt & ~pin.write_select_n & ~pin.write_enable_n &
                   (free_w >= OFS_W'(in_units));

    always_ff @(posedge clk_sys_i) begin
        if (wr_ok) begin
            mem[wr_ptr[AW-1:0]] <= pin.write_data[UNIT_W-1:0];
            if (pin.input_width_select) begin
                mem[AW'(wr_ptr + ONE_P)] <= pin.write_data[WIDE_W-1:UNIT_W];
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            wr_ptr <= '0;
        end else if (wr_ok) begin
            wr_ptr <= wr_ptr + in_units;
        end
    end

    // age since the last reference edge decides if a snapshot sees it
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            w_age <= AGE_MAX;
            wr_ptr_prev <= '0;
        end else if (w_ref) begin
            w_age <= '0;
            wr_ptr_prev <= wr_ptr;
        end else if (w_age != AGE_MAX) begin
            w_age <= w_age + 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            r_age <= AGE_MAX;
            rd_ptr_prev <= '0;
        end else if (r_ref) begin
            r_age <= '0;
            rd_ptr_prev <= rd_ptr;
        end else if (r_age != AGE_MAX) begin
            r_age <= r_age + 1'b1;
        end
    end

    // crossing snapshots: stage one for standard flags, stage two for
    // the fall-through load
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            r_wsnap1 <= '0;
            r_wsnap2 <= '0;
        end else if (r_rise) begin
            r_wsnap1 <= (w_age >= w_skew) ? wr_ptr : wr_ptr_prev;
            r_wsnap2 <= r_wsnap1;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            w_rsnap <= '0;
        end else if (w_rise) begin
            w_rsnap <= (r_age >= SKEW_RISE_CYC) ? rd_ptr : rd_ptr_prev;
        end
    end

    // two-entry buffer between storage and the output register; it stalls
    // the prefetch while the reader holds off
    logic [WIDE_W-1:0] buf_data [2];
    logic buf_wp, buf_rp;
    logic [1:0] buf_cnt;
    logic [PW-1:0] vis_units;
    logic pf_valid, buf_ready, push, load, rd_req;
    logic [WIDE_W-1:0] pf_word;
    logic out_valid;
    assign vis_units = (fwft ? r_wsnap2 : r_wsnap1) - rd_ptr;
    assign pf_valid = vis_units >= out_units;
    assign buf_ready = buf_cnt != BUF_FULL;
    assign push = pf_valid & buf_ready;
    assign pf_word = pin.output_width_select ?
        {mem[AW'(rd_ptr + ONE_P)], mem[rd_ptr[AW-1:0]]} :
        {{(WIDE_W-UNIT_W){1'b0}}, mem[rd_ptr[AW-1:0]]};
    assign rd_req = ~pin.read_select_n & ~pin.read_enable_n;
    assign load = r_evt & (buf_cnt != 2'h0) &
        (fwft ? (~out_valid | rd_req) : (rd_req & empty_flag_n_o));

    always_ff @(posedge clk_sys_i) begin
        if (push) begin
            buf_data[buf_wp] <= pf_word;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            buf_wp <= 1'b0;
            buf_rp <= 1'b0;
            buf_cnt <= 2'h0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                buf_wp <= ~buf_wp;
                rd_ptr <= rd_ptr + out_units;
            end
            if (load) begin
                buf_rp <= ~buf_rp;
            end
            buf_cnt <= buf_cnt + {1'b0, push} - {1'b0, load};
        end
    end

    // committed read pointer counts 10-bit units the reader has taken
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            rd_cptr <= '0;
        end else if (load) begin
            rd_cptr <= rd_cptr + out_units;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            read_data_out_o <= '0;
        end else if (load) begin
            read_data_out_o <= buf_data[buf_rp];
        end
    end

    // output ready: word held in the output register in fall-through mode
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            out_valid <= 1'b0;
        end else if (!fwft) begin
            out_valid <= 1'b0;
        end else if (load) begin
            out_valid <= 1'b1;
        end else if (r_evt & rd_req) begin
            out_valid <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            output_ready_n_o <= READY_OUT_RST;
        end else if (!fwft) begin
            output_ready_n_o <= READY_OUT_RST;
        end else if (r_evt) begin
            output_ready_n_o <= ~(load | (out_valid & ~rd_req));
        end
    end

    // empty flag looks at the buffer filled from stage one
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            empty_flag_n_o <= EMPTY_RST;
        end else if (fwft) begin
            empty_flag_n_o <= 1'b1;
        end else if (r_rise) begin
            empty_flag_n_o <= (buf_cnt - {1'b0, load}) != 2'h0;
        end
    end

    // echo only moves on read clock edges
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            echo_read_enable_n_o <= ECHO_RST;
        end else if (r_evt) begin
            echo_read_enable_n_o <= ~load;
        end
    end

    // write side full and input ready use the pre-edge snapshot, so a
    // read shows up one write cycle after it is seen
    logic full_next;
    assign full_next = (free_w - (wr_ok ? OFS_W'(in_units) : '0)) <
                       OFS_W'(in_units);

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            full_flag_n_o <= FULL_RST;
            input_ready_n_o <= READY_IN_RST;
        end else if (w_rise) begin
            full_flag_n_o <= fwft | ~full_next;
            input_ready_n_o <= ~fwft | full_next;
        end
    end

    // almost flags: each port's own view, split between ports when the
    // flag timing select is low
    logic [PW-1:0] used_r;
    logic ae_hit_r, ae_hit_w, af_hit_r, af_hit_w;
    assign used_r = r_wsnap1 - rd_cptr;
    assign ae_hit_r = OFS_W'(used_r) <= pin.almost_empty_offset;
    assign ae_hit_w = OFS_W'(used_w) <= pin.almost_empty_offset;
    assign af_hit_w = OFS_W'(used_w) >= (DEPTH_W - pin.almost_full_offset);
    assign af_hit_r = OFS_W'(used_r) >= (DEPTH_W - pin.almost_full_offset);

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            almost_empty_flag_n_o <= AEMPTY_RST;
        end else if (sync_flags) begin
            if (r_rise) begin
                almost_empty_flag_n_o <= ~ae_hit_r;
            end
        end else if (r_rise & ae_hit_r) begin
            almost_empty_flag_n_o <= 1'b0;
        end else if (w_rise & ~ae_hit_w) begin
            almost_empty_flag_n_o <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            almost_full_flag_n_o <= AFULL_RST;
        end else if (sync_flags) begin
            if (w_rise) begin
                almost_full_flag_n_o <= ~af_hit_w;
            end
        end else if (w_rise & af_hit_w) begin
            almost_full_flag_n_o <= 1'b0;
        end else if (r_rise & ~af_hit_r) begin
            almost_full_flag_n_o <= 1'b1;
        end
    end

    // data pin drive follows select and output enable only
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            read_data_oe_n_o <= DRIVE_OFF;
        end else begin
            read_data_oe_n_o <= pin.read_select_n | pin.output_enable_n;
        end
    end

    // dual mode leaves only two lanes in service; the rest behave alike
    always_ff @(posedge clk_sys_i) begin
        if (!rstn_i) begin
            lane_used_o <= 1'b0;
        end else begin
            lane_used_o <= (pin.fifo_count_select == FIFO_COUNT_QUAD) |
                           (LANE_ID == DUAL_LANE_A) |
                           (LANE_ID == DUAL_LANE_B);
        end
    end

endmodule : frsft_lane

/* File: tb/frsft_properties.sv */
// concurrent checks on one lane's pins, bound into every lane instance
// assumes port clock edges are several system cycles apart
module frsft_properties
    import frsft_pkg::*;
#(
    parameter int LANE_ID = 0
) (
    input wire logic clk_sys_i, // system clock
    input wire logic rstn_i, // reset, active low
    input wire logic write_clock_i, // write clock pin
    input wire logic read_clock_i, // read clock pin
    input wire logic read_select_n_i, // read select
    input wire logic output_enable_n_i, // output enable
    input wire logic fifo_count_select_i, // quad or dual
    input wire logic fall_through_select_i, // fall-through mode
    input wire logic flag_timing_select_i, // sync almost flags
    input wire logic empty_flag_n_o, // empty
    input wire logic output_ready_n_o, // word ready
    input wire logic full_flag_n_o, // full
    input wire logic input_ready_n_o, // room ready
    input wire logic almost_empty_flag_n_o, // almost empty
    input wire logic almost_full_flag_n_o, // almost full
    input wire logic echo_read_enable_n_o, // echo
    input wire logic read_data_oe_n_o, // data pin enable
    input wire logic lane_used_o // lane in service
);
    timeunit 1ns;
    timeprecision 100ps;
    logic rc_q;
    logic wc_q;
    logic [5:0] rd_seen;
    logic [5:0] rd_any;
    logic [5:0] wr_seen;
    wire sel_off = read_select_n_i | output_enable_n_i;

    // pins pass two flops and an edge detect, so a flag moves in a narrow
    // window after its port clock rise; echo and ready may also use falls
    always_ff @(posedge clk_sys_i) begin
        rc_q <= read_clock_i;
        rd_seen <= {rd_seen[4:0], read_clock_i & ~rc_q};
        rd_any <= {rd_any[4:0], read_clock_i ^ rc_q};
    end
    always_ff @(posedge clk_sys_i) begin
        wc_q <= write_clock_i;
        wr_seen <= {wr_seen[4:0], write_clock_i & ~wc_q};
    end

    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);

    sequence s_pins_settled;
        (rstn_i && $stable(sel_off)) [*4];
    endsequence
    sequence s_lane_up;
        rstn_i [*3];
    endsequence
    property p_timed(logic [1:0] sig, logic [5:0] seen);
        $changed(sig) |-> |seen[3:1];
    endproperty

    AST_OE_FOLLOWS_PINS:
        assert property (s_pins_settled |-> read_data_oe_n_o == sel_off)
        else $error("data enable does not follow select and enable");
    AST_LANE_IN_SERVICE:
        assert property (s_lane_up |->
            lane_used_o == (fifo_count_select_i || LANE_ID % 2 == 0))
        else $error("lane service flag wrong for mode");
    AST_ECHO_ON_READ_CLOCK:
        assert property (p_timed({echo_read_enable_n_o, output_ready_n_o},
            rd_any))
        else $error("echo or ready moved away from a read clock edge");
    AST_EMPTY_ON_READ_CLOCK:
        assert property (p_timed(empty_flag_n_o | fall_through_select_i,
            rd_seen))
        else $error("empty moved away from a read clock rise");
    AST_ROOM_ON_WRITE_CLOCK:
        assert property (p_timed(full_flag_n_o & input_ready_n_o, wr_seen))
        else $error("full or room moved away from a write clock edge");
    AST_AEMPTY_SYNC:
        assert property (flag_timing_select_i && $changed(almost_empty_flag_n_o)
            |-> |rd_seen[3:1])
        else $error("almost empty moved off the read clock");
    AST_AFULL_SYNC:
        assert property (flag_timing_select_i && $changed(almost_full_flag_n_o)
            |-> |wr_seen[3:1])
        else $error("almost full moved off the write clock");
    AST_READY_WITH_ECHO:
        assert property ($fell(output_ready_n_o) |-> !echo_read_enable_n_o)
        else $error("word ready without echo");
    AST_ECHO_NEEDS_WORD:
        assert property (!fall_through_select_i
            && $fell(echo_read_enable_n_o) |-> $past(empty_flag_n_o, 3))
        else $error("echo fell while empty");
endmodule : frsft_properties

bind frsft_lane frsft_properties #(.LANE_ID(LANE_ID)) u_props (
    .clk_sys_i, .rstn_i, .write_clock_i, .read_clock_i, .read_select_n_i,
    .output_enable_n_i, .fifo_count_select_i, .fall_through_select_i,
    .flag_timing_select_i, .empty_flag_n_o, .output_ready_n_o,
    .full_flag_n_o, .input_ready_n_o, .almost_empty_flag_n_o,
    .almost_full_flag_n_o, .echo_read_enable_n_o, .read_data_oe_n_o,
    .lane_used_o
);

/* File: tb/frsft_reader.sv */
// reading controller model: free-running read clock and read strobes
// assumes the bench raises want_i while it wants words drained
module frsft_reader
    import frsft_pkg::*;
#(
    parameter int HALF = 4
) (
    input wire logic clk_sys_i, // system clock
    input wire logic want_i, // bench asks for reads
    output logic read_clock_o, // read port clock
    output logic read_select_n_o, // read select
    output logic read_enable_n_o // read enable
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] cnt = 8'h00;
    logic clk_q = 1'b0;
    logic sel_q = 1'b1;
    logic en_q = 1'b1;

    assign read_clock_o = clk_q;
    assign read_select_n_o = sel_q;
    assign read_enable_n_o = en_q;

    // never stopped, so the empty flag can always settle
    always @(posedge clk_sys_i) begin
        cnt <= (cnt == 8'(HALF - 1)) ? 8'h00 : cnt + 8'h01;
        if (cnt == 8'(HALF - 1)) begin
            clk_q <= ~clk_q;
            if (clk_q) begin
                // strobes move on the fall, clear of the sampling rise
                sel_q <= !want_i;
                en_q <= !(want_i && !sel_q);
            end
        end
    end
endmodule : frsft_reader

/* File: tb/test_fifo_read_side_flag_timing.sv */
// self-checking bench for one lane: writer, reader model, result queue
// assumes port clocks of seven and eight system cycles per period
module test_fifo_read_side_flag_timing
    import frsft_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys_i = 1'b0;
    logic rstn_i = 1'b0;
    logic write_clock_i = 1'b0;
    logic write_select_n_i = 1'b0;
    logic write_enable_n_i = 1'b1;
    logic output_enable_n_i = 1'b0;
    logic [WIDE_W-1:0] write_data_i = 20'h00000;
    logic fifo_count_select_i = 1'b1;
    logic write_double_rate_i = 1'b0;
    logic read_double_rate_i = 1'b0;
    logic fall_through_select_i = 1'b0;
    logic flag_timing_select_i = 1'b1;
    logic input_width_select_i = 1'b0;
    logic output_width_select_i = 1'b0;
    logic [OFS_W-1:0] almost_empty_offset_i = 16'h0002;
    logic [OFS_W-1:0] almost_full_offset_i = 16'h0002;
    logic read_clock_i, read_select_n_i, read_enable_n_i;
    logic empty_flag_n_o, output_ready_n_o, full_flag_n_o, input_ready_n_o;
    logic almost_empty_flag_n_o, almost_full_flag_n_o, echo_read_enable_n_o;
    logic [WIDE_W-1:0] read_data_out_o;
    logic read_data_oe_n_o, lane_used_o;
    logic want = 1'b0;
    logic rc_d = 1'b0;
    logic [2:0] wcnt = 3'h0;
    logic [3:0] mcnt = 4'h0;
    int n_errors = 0;
    int samples_checked = 0;
    logic [WIDE_W-1:0] exp_q[$];
    logic [WIDE_W-1:0] wr_q[$];

    frsft_lane #(.DEPTH(8), .LANE_ID(0)) dut (
        .clk_sys_i, .rstn_i, .write_clock_i, .read_clock_i,
        .write_select_n_i, .write_enable_n_i, .read_select_n_i,
        .read_enable_n_i, .output_enable_n_i, .write_data_i,
        .fifo_count_select_i, .write_double_rate_i, .read_double_rate_i,
        .fall_through_select_i, .flag_timing_select_i, .input_width_select_i,
        .output_width_select_i, .almost_empty_offset_i, .almost_full_offset_i,
        .empty_flag_n_o, .output_ready_n_o, .full_flag_n_o, .input_ready_n_o,
        .almost_empty_flag_n_o, .almost_full_flag_n_o, .echo_read_enable_n_o,
        .read_data_out_o, .read_data_oe_n_o, .lane_used_o
    );
    frsft_reader #(.HALF(4)) u_reader (
        .clk_sys_i, .want_i(want), .read_clock_o(read_clock_i),
        .read_select_n_o(read_select_n_i), .read_enable_n_o(read_enable_n_i)
    );

    initial begin
        forever #50 clk_sys_i = ~clk_sys_i;
    end

    task automatic cmp_bit(input string what, input logic ev, input logic got);
        samples_checked++;
        if (got !== ev) begin
            n_errors++;
            $display("CHECK FAILED %s expected %b seen %b", what, ev, got);
        end
    endtask : cmp_bit

    task automatic cmp_word(input logic [19:0] ev, input logic [19:0] got);
        samples_checked++;
        if (got !== ev) begin
            n_errors++;
            $display("CHECK FAILED read data expected %h seen %h", ev, got);
        end
    endtask : cmp_word

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : test_done

    task automatic tick(inout int n, input int lim);
        @(posedge clk_sys_i);
        n++;
        if (n > lim) begin
            n_errors++;
            $display("CHECK FAILED wait bound expected %0d seen %0d", lim, n);
            test_done();
        end
    endtask : tick

    // writer: the write clock runs free, strobe and data move on its fall
    always @(posedge clk_sys_i) begin
        wcnt <= (wcnt == 3'h6) ? 3'h0 : wcnt + 3'h1;
        write_clock_i <= (wcnt < 3'h3);
        if (wcnt == 3'h3) begin
            write_enable_n_i <= (wr_q.size() == 0);
            if (wr_q.size() != 0) write_data_i <= wr_q.pop_front();
        end
    end

    // monitor: a low echo after a read clock rise means one new word
    always @(posedge clk_sys_i) begin
        rc_d <= read_clock_i;
        mcnt <= (read_clock_i && !rc_d) ? 4'h1 : mcnt + 4'h1;
        if (mcnt == 4'h5) begin
            output_enable_n_i <= 1'($urandom_range(1));
            if (echo_read_enable_n_o === 1'b0) begin
                if (exp_q.size() == 0) cmp_bit("word expected", 1'b1, 1'b0);
                else cmp_word(exp_q.pop_front(), read_data_out_o);
            end
        end
    end

    task automatic put_word(input logic wide);
        logic [WIDE_W-1:0] w;
        w = wide ? 20'($urandom) : {10'h000, 10'($urandom)};
        wr_q.push_back(w);
        exp_q.push_back({10'h000, w[9:0]});
        if (wide) exp_q.push_back({10'h000, w[19:10]});
    endtask : put_word

    task automatic restart(input logic ft, input logic wide);
        rstn_i <= 1'b0;
        want <= 1'b0;
        fall_through_select_i <= ft;
        input_width_select_i <= wide;
        fifo_count_select_i <= !wide;
        almost_empty_offset_i <= 16'(1 + $urandom_range(1));
        almost_full_offset_i <= 16'(1 + $urandom_range(1));
        repeat (20) @(posedge clk_sys_i);
        exp_q.delete();
        wr_q.delete();
        rstn_i <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
    endtask : restart

    task automatic run(input logic ft, input logic wide);
        int n;
        restart(ft, wide);
        cmp_bit("idle flag", 1'b0, ft ? !output_ready_n_o : empty_flag_n_o);
        cmp_bit("lane used", 1'b1, lane_used_o);
        put_word(wide);
        n = 0;
        while (ft ? output_ready_n_o : !empty_flag_n_o) tick(n, 60);
        cmp_bit("first word delay", 1'b1,
            n >= (ft ? 16 : 8) && n <= (ft ? 48 : 40));
        for (int i = 1; i < (wide ? 6 : 12); i++) put_word(wide);
        n = 0;
        while (wr_q.size() != 0) tick(n, 200);
        repeat (24) @(posedge clk_sys_i);
        cmp_bit("room flag", 1'b1, ft ? input_ready_n_o : !full_flag_n_o);
        cmp_bit("almost full", 1'b0, almost_full_flag_n_o);
        cmp_bit("almost empty", 1'b1, almost_empty_flag_n_o);
        want <= 1'b1;
        n = 0;
        while (ft ? !output_ready_n_o : empty_flag_n_o) tick(n, 400);
        repeat (24) @(posedge clk_sys_i);
        cmp_bit("dropped words", 1'b1, exp_q.size() inside {[1:4]});
        cmp_bit("room flag", 1'b0, ft ? input_ready_n_o : !full_flag_n_o);
        cmp_bit("almost full", 1'b1, almost_full_flag_n_o);
        cmp_bit("almost empty", 1'b0, almost_empty_flag_n_o);
        want <= 1'b0;
        $display("test done: fall-through %0b wide %0b", ft, wide);
    endtask : run

    initial begin
        void'($urandom(32'hBD83));
        run(1'b0, 1'b0);
        run(1'b1, 1'b0);
        run(1'b0, 1'b1);
        test_done();
    end
endmodule : test_fifo_read_side_flag_timing
